// ===== hw/port_config_word_loader.sv
// Loader that scatters configuration memory words into per-port configuration fields
`timescale 1ns/1ps
module port_config_word_loader (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic mem_req,
    output logic [7:0] mem_addr,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic [15:0] mem_rdata,
    output cfg_loader_pkg::pm_fields_t port4_pm,
    output cfg_loader_pkg::pm_fields_t port5_pm,
    output cfg_loader_pkg::dn_fields_t port0_dn,
    output cfg_loader_pkg::dn_fields_t port1_dn,
    output logic cfg_ready
);
    import cfg_loader_pkg::*;

    loader_state_t s_ff;
    loader_state_t nxt_s;
    logic [31:0] rd_word;
    logic addr_ok;

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Word address of each load step
    function automatic logic [7:0] word_addr(input logic [2:0] idx);
        logic [7:0] a;
        a = WADDR_P4_PM;
        if (idx == 3'h1) begin
            a = WADDR_P4_DATA;
        end else if (idx == 3'h2) begin
            a = WADDR_P5_PM;
        end else if (idx == 3'h3) begin
            a = WADDR_P5_DATA;
        end else if (idx == 3'h4) begin
            a = WADDR_P0_DN;
        end else if (idx == 3'h5) begin
            a = WADDR_P1_DN;
        end
        return a;
    endfunction

    // Power capability word into a port's power fields, data kept
    function automatic pm_fields_t load_pm(input pm_fields_t old, input logic [15:0] w);
        pm_fields_t f;
        f = old;
        f.nsr = w[WB_NSR];
        f.aux = w[WB_AUX_LSB +: 3];
        f.d1 = w[WB_D1];
        f.d2 = w[WB_D2];
        f.pme = w[WB_PME_LSB +: 2];
        return f;
    endfunction

    // Downstream port word; slot-implemented only where the word carries it
    function automatic dn_fields_t load_dn(input dn_fields_t old, input logic [15:0] w, input logic has_slot);
        dn_fields_t f;
        f = old;
        if (has_slot) begin
            f.slot_impl = w[WB_SLOT_IMPL];
        end
        f.slot_clk = w[WB_SLOT_CLK];
        f.dsi = w[WB_DSI];
        f.lpvc = w[WB_LPVC];
        f.port_num = w[WB_PNUM_LSB +: 3];
        f.tc_map = w[WB_TCMAP_LSB +: 7];
        return f;
    endfunction

    // Power capability dword at 40h
    function automatic logic [31:0] pm_dw40(input pm_fields_t f);
        logic [31:0] d;
        d = 32'h0000_0000;
        d[DB_AUX_LSB +: 3] = f.aux;
        d[DB_D1] = f.d1;
        d[DB_D2] = f.d2;
        d[DB_PME_LSB +: 2] = f.pme;
        return d;
    endfunction

    // Power control and data dword at 44h
    function automatic logic [31:0] pm_dw44(input pm_fields_t f);
        logic [31:0] d;
        d = 32'h0000_0000;
        d[DB_NSR] = f.nsr;
        d[DB_DATA_LSB +: 8] = f.data;
        return d;
    endfunction

    // One dword of a downstream port, selected by register offset within the group
    function automatic logic [31:0] dn_dw(input dn_fields_t f, input logic [2:0] sel);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (sel == 3'h0) begin
            d[DB_DSI] = f.dsi;
        end else if (sel == 3'h1) begin
            d[DB_PNUM_LSB +: 3] = f.port_num;
        end else if (sel == 3'h2) begin
            d[DB_SLOT_CLK] = f.slot_clk;
        end else if (sel == 3'h3) begin
            d[DB_LPVC] = f.lpvc;
        end else if (sel == 3'h4) begin
            d[DB_TCMAP_LSB +: 7] = f.tc_map;
        end else begin
            d[DB_SLOT_IMPL] = f.slot_impl;
        end
        return d;
    endfunction

    // ----------------------------------------------------------------
    // Register read decode
    // ----------------------------------------------------------------

    // Read word for the address phase; unmapped addresses read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        addr_ok = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'b00);
        if (!addr_ok) begin
            rd_word = 32'h0000_0000;
        end else if (haddr[7:0] == OFS_STATUS) begin
            rd_word[STAT_DONE_BIT] = s_ff.done;
            rd_word[STAT_BUSY_BIT] = !s_ff.done;
            rd_word[STAT_LOADED_LSB +: 6] = s_ff.loaded;
        end else if (haddr[7:0] == OFS_P4_40) begin
            rd_word = pm_dw40(s_ff.p4);
        end else if (haddr[7:0] == OFS_P4_44) begin
            rd_word = pm_dw44(s_ff.p4);
        end else if (haddr[7:0] == OFS_P5_40) begin
            rd_word = pm_dw40(s_ff.p5);
        end else if (haddr[7:0] == OFS_P5_44) begin
            rd_word = pm_dw44(s_ff.p5);
        end else if (haddr[7:0] == OFS_P0_40) begin
            rd_word = dn_dw(s_ff.p0, 3'h0);
        end else if (haddr[7:0] == OFS_P0_CC) begin
            rd_word = dn_dw(s_ff.p0, 3'h1);
        end else if (haddr[7:0] == OFS_P0_D0) begin
            rd_word = dn_dw(s_ff.p0, 3'h2);
        end else if (haddr[7:0] == OFS_P0_144) begin
            rd_word = dn_dw(s_ff.p0, 3'h3);
        end else if (haddr[7:0] == OFS_P0_154) begin
            rd_word = dn_dw(s_ff.p0, 3'h4);
        end else if (haddr[7:0] == OFS_P1_40) begin
            rd_word = dn_dw(s_ff.p1, 3'h0);
        end else if (haddr[7:0] == OFS_P1_CC) begin
            rd_word = dn_dw(s_ff.p1, 3'h1);
        end else if (haddr[7:0] == OFS_P1_D0) begin
            rd_word = dn_dw(s_ff.p1, 3'h2);
        end else if (haddr[7:0] == OFS_P1_144) begin
            rd_word = dn_dw(s_ff.p1, 3'h3);
        end else if (haddr[7:0] == OFS_P1_154) begin
            rd_word = dn_dw(s_ff.p1, 3'h4);
        end else if (haddr[7:0] == OFS_P1_C0) begin
            rd_word = dn_dw(s_ff.p1, 3'h5);
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------

    // Loader sequence and bus slave in one pass
    always_comb begin
        nxt_s = s_ff;
        nxt_s.hreadyout = 1'b1;

        // Load sequence: one word per step, fields untouched on a failed read
        case (s_ff.st)
            ST_START: begin
                nxt_s.idx = 3'h0;
                nxt_s.done = 1'b0;
                nxt_s.loaded = 6'h00;
                nxt_s.st = ST_REQ;
            end
            ST_REQ: begin
                nxt_s.mem_req = 1'b1;
                nxt_s.mem_addr = word_addr(s_ff.idx);
                nxt_s.st = ST_WAIT;
            end
            ST_WAIT: begin
                if (mem_ack) begin
                    nxt_s.mem_req = 1'b0;
                    if (!mem_err) begin
                        nxt_s.loaded[s_ff.idx] = 1'b1;
                        if (s_ff.idx == 3'h0) begin
                            nxt_s.p4 = load_pm(s_ff.p4, mem_rdata);
                        end else if (s_ff.idx == 3'h1) begin
                            nxt_s.p4.data = mem_rdata[WB_DATA_LSB +: 8];
                        end else if (s_ff.idx == 3'h2) begin
                            nxt_s.p5 = load_pm(s_ff.p5, mem_rdata);
                        end else if (s_ff.idx == 3'h3) begin
                            nxt_s.p5.data = mem_rdata[WB_DATA_LSB +: 8];
                        end else if (s_ff.idx == 3'h4) begin
                            nxt_s.p0 = load_dn(s_ff.p0, mem_rdata, 1'b0);
                        end else begin
                            nxt_s.p1 = load_dn(s_ff.p1, mem_rdata, 1'b1);
                        end
                    end
                    if (s_ff.idx == LAST_IDX) begin
                        nxt_s.st = ST_DONE;
                        nxt_s.done = 1'b1;
                    end else begin
                        nxt_s.idx = s_ff.idx + 3'h1;
                        nxt_s.st = ST_REQ;
                    end
                end
            end
            ST_DONE: begin
                nxt_s.done = 1'b1;
            end
            default: begin
                nxt_s.st = ST_START;
            end
        endcase

        // Data phase of a write: reload request honoured only when idle
        nxt_s.wr_pend = 1'b0;
        if (s_ff.wr_pend && (s_ff.wr_addr == OFS_CTRL) && hwdata[CTRL_RELOAD_BIT] && (s_ff.st == ST_DONE)) begin
            nxt_s.st = ST_START;
            nxt_s.done = 1'b0;
        end

        // Address phase: reads registered for the data phase, writes remembered
        if (hsel && htrans[1] && hready) begin
            if (hwrite) begin
                nxt_s.wr_pend = addr_ok;
                nxt_s.wr_addr = haddr[7:0];
            end else begin
                nxt_s.hrdata = rd_word;
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------

    // All state held while the clock enable is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff <= STATE_RST;
        end else if (clk_en) begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all from the state register except hresp, which is tied low
    // ----------------------------------------------------------------
    assign hreadyout = s_ff.hreadyout;
    assign hresp = 1'b0;                 // Always OKAY
    assign hrdata = s_ff.hrdata;
    assign mem_req = s_ff.mem_req;
    assign mem_addr = s_ff.mem_addr;
    assign port4_pm = s_ff.p4;
    assign port5_pm = s_ff.p5;
    assign port0_dn = s_ff.p0;
    assign port1_dn = s_ff.p1;
    assign cfg_ready = s_ff.done;

endmodule

// ===== hw/cfg_loader_pkg.sv
// Constants, field layouts and state types of the port configuration word loader
package cfg_loader_pkg;

    // ----------------------------------------------------------------
    // Configuration memory word addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] WADDR_P4_PM = 8'h58;
    localparam logic [7:0] WADDR_P4_DATA = 8'h59;
    localparam logic [7:0] WADDR_P5_PM = 8'h5a;
    localparam logic [7:0] WADDR_P5_DATA = 8'h5b;
    localparam logic [7:0] WADDR_P0_DN = 8'h60;
    localparam logic [7:0] WADDR_P1_DN = 8'h62;
    localparam logic [2:0] LAST_IDX = 3'h5;

    // ----------------------------------------------------------------
    // Bit positions inside the 16-bit words
    // ----------------------------------------------------------------
    localparam int WB_NSR = 0;
    localparam int WB_AUX_LSB = 1;
    localparam int WB_D1 = 4;
    localparam int WB_D2 = 5;
    localparam int WB_PME_LSB = 6;
    localparam int WB_DATA_LSB = 8;
    localparam int WB_SLOT_IMPL = 0;
    localparam int WB_SLOT_CLK = 1;
    localparam int WB_DSI = 2;
    localparam int WB_LPVC = 3;
    localparam int WB_PNUM_LSB = 4;
    localparam int WB_TCMAP_LSB = 9;

    // ----------------------------------------------------------------
    // Bit positions inside the configuration dwords
    // ----------------------------------------------------------------
    localparam int DB_NSR = 3;
    localparam int DB_AUX_LSB = 22;
    localparam int DB_D1 = 25;
    localparam int DB_D2 = 26;
    localparam int DB_PME_LSB = 28;
    localparam int DB_DATA_LSB = 24;
    localparam int DB_SLOT_CLK = 28;
    localparam int DB_DSI = 21;
    localparam int DB_LPVC = 4;
    localparam int DB_PNUM_LSB = 24;
    localparam int DB_TCMAP_LSB = 1;
    localparam int DB_SLOT_IMPL = 24;

    // ----------------------------------------------------------------
    // Bus register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_P4_40 = 8'h10;
    localparam logic [7:0] OFS_P4_44 = 8'h14;
    localparam logic [7:0] OFS_P5_40 = 8'h18;
    localparam logic [7:0] OFS_P5_44 = 8'h1c;
    localparam logic [7:0] OFS_P0_40 = 8'h20;
    localparam logic [7:0] OFS_P0_CC = 8'h24;
    localparam logic [7:0] OFS_P0_D0 = 8'h28;
    localparam logic [7:0] OFS_P0_144 = 8'h2c;
    localparam logic [7:0] OFS_P0_154 = 8'h30;
    localparam logic [7:0] OFS_P1_40 = 8'h34;
    localparam logic [7:0] OFS_P1_CC = 8'h38;
    localparam logic [7:0] OFS_P1_D0 = 8'h3c;
    localparam logic [7:0] OFS_P1_144 = 8'h40;
    localparam logic [7:0] OFS_P1_154 = 8'h44;
    localparam logic [7:0] OFS_P1_C0 = 8'h48;
    localparam int CTRL_RELOAD_BIT = 0;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_LOADED_LSB = 8;

    // ----------------------------------------------------------------
    // Field groups and state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic nsr;
        logic [2:0] aux;
        logic d1;
        logic d2;
        logic [1:0] pme;
        logic [7:0] data;
    } pm_fields_t;

    typedef struct packed {
        logic slot_impl;
        logic slot_clk;
        logic dsi;
        logic lpvc;
        logic [2:0] port_num;
        logic [6:0] tc_map;
    } dn_fields_t;

    typedef enum logic [1:0] {
        ST_START = 2'b00,
        ST_REQ = 2'b01,
        ST_WAIT = 2'b10,
        ST_DONE = 2'b11
    } ld_state_t;

    typedef struct packed {
        ld_state_t st;
        logic [2:0] idx;
        logic done;
        logic [5:0] loaded;
        logic mem_req;
        logic [7:0] mem_addr;
        pm_fields_t p4;
        pm_fields_t p5;
        dn_fields_t p0;
        dn_fields_t p1;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
        logic hreadyout;
    } loader_state_t;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam pm_fields_t PM_RST = '{nsr: 1'b0, aux: 3'h0, d1: 1'b0, d2: 1'b0, pme: 2'h0, data: 8'h00};
    localparam dn_fields_t P0_RST = '{slot_impl: 1'b0, slot_clk: 1'b0, dsi: 1'b0, lpvc: 1'b0,
                                      port_num: 3'h0, tc_map: 7'h00};
    localparam dn_fields_t P1_RST = '{slot_impl: 1'b0, slot_clk: 1'b0, dsi: 1'b0, lpvc: 1'b0,
                                      port_num: 3'h1, tc_map: 7'h00};
    localparam loader_state_t STATE_RST = '{st: ST_START, idx: 3'h0, done: 1'b0, loaded: 6'h00,
                                            mem_req: 1'b0, mem_addr: 8'h00, p4: PM_RST, p5: PM_RST,
                                            p0: P0_RST, p1: P1_RST, wr_pend: 1'b0, wr_addr: 8'h00,
                                            hrdata: 32'h0000_0000, hreadyout: 1'b1};

endpackage

// ===== test/port_config_word_loader_properties.sv
// Concurrent checks on the loader's bus and memory ports
`timescale 1ns/1ps
module loader_checker
    import cfg_loader_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic mem_req,
    input wire logic [7:0] mem_addr,
    input wire logic mem_ack,
    input wire logic mem_err,
    input wire logic [15:0] mem_rdata,
    input wire pm_fields_t port4_pm,
    input wire pm_fields_t port5_pm,
    input wire dn_fields_t port0_dn,
    input wire dn_fields_t port1_dn,
    input wire logic cfg_ready
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // A memory answer that the loader really takes
    wire logic take = mem_req && mem_ack && clk_en;
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    chk_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("bus answer not zero-wait OKAY");
    chk_req_holds: assert property (mem_req && !take |=> mem_req && $stable(mem_addr))
        else $error("memory request dropped or moved early");
    chk_req_drops: assert property (take |=> !mem_req)
        else $error("memory request not dropped after answer");
    chk_port4_power: assert property (take && !mem_err && mem_addr == WADDR_P4_PM |=>
        {port4_pm.pme, port4_pm.d2, port4_pm.d1, port4_pm.aux, port4_pm.nsr} == $past(mem_rdata[7:0]))
        else $error("port4 power fields wrong");
    chk_port4_data: assert property (take && !mem_err && mem_addr == WADDR_P4_DATA |=>
        port4_pm.data == $past(mem_rdata[15:8])) else $error("port4 data wrong");
    chk_port5_power: assert property (take && !mem_err && mem_addr == WADDR_P5_PM |=>
        {port5_pm.pme, port5_pm.d2, port5_pm.d1, port5_pm.aux, port5_pm.nsr} == $past(mem_rdata[7:0]))
        else $error("port5 power fields wrong");
    chk_port5_data: assert property (take && !mem_err && mem_addr == WADDR_P5_DATA |=>
        port5_pm.data == $past(mem_rdata[15:8])) else $error("port5 data wrong");
    chk_port0_fields: assert property (take && !mem_err && mem_addr == WADDR_P0_DN |=>
        {port0_dn.tc_map, port0_dn.port_num, port0_dn.lpvc, port0_dn.dsi, port0_dn.slot_clk}
        == {$past(mem_rdata[15:9]), $past(mem_rdata[6:1])}) else $error("port0 fields wrong");
    chk_port1_fields: assert property (take && !mem_err && mem_addr == WADDR_P1_DN |=>
        {port1_dn.tc_map, port1_dn.port_num, port1_dn.lpvc, port1_dn.dsi, port1_dn.slot_clk, port1_dn.slot_impl}
        == {$past(mem_rdata[15:9]), $past(mem_rdata[6:0])}) else $error("port1 fields wrong");
    chk_err_keeps: assert property (take && mem_err |=>
        $stable(port4_pm) && $stable(port5_pm) && $stable(port0_dn) && $stable(port1_dn))
        else $error("fields changed on a failed word");
    chk_ready_after: assert property (take && mem_addr == WADDR_P1_DN |=> cfg_ready)
        else $error("ready not raised after last word");
    chk_ready_quiet: assert property (cfg_ready |-> !mem_req)
        else $error("memory request while ready");
    cover property (take && mem_err);
    cover property (take && mem_addr == WADDR_P1_DN);
    cover property (!clk_en && mem_req);
endmodule
bind port_config_word_loader loader_checker loader_checker_inst (.hclk, .hresetn, .clk_en, .hreadyout, .hresp,
    .mem_req, .mem_addr, .mem_ack, .mem_err, .mem_rdata, .port4_pm, .port5_pm, .port0_dn, .port1_dn, .cfg_ready);

// ===== test/cfg_word_memory.sv
// Behavioural model of the configuration word memory behind the loader
`timescale 1ns/1ps
module cfg_word_memory (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic mem_req,
    input wire logic [7:0] mem_addr,
    input wire logic content_sel,
    input wire logic [3:0] wait_cycles,
    input wire logic [7:0] err_addr,
    output logic mem_ack,
    output logic mem_err,
    output logic [15:0] mem_rdata
);
    logic [3:0] cnt_ff;
    // One answer pulse after each chosen wait while the request stays up; data toggles when not valid
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= 4'h0;
            mem_ack <= 1'b0;
            mem_err <= 1'b0;
            mem_rdata <= 16'h0000;
        end else begin
            mem_ack <= 1'b0;
            mem_err <= 1'b0;
            mem_rdata <= ~mem_rdata;
            cnt_ff <= 4'h0;
            if (mem_req && !mem_ack && cnt_ff == wait_cycles) begin
                mem_ack <= 1'b1;
                mem_err <= (mem_addr == err_addr);
                mem_rdata <= content_sel ? {~mem_addr, mem_addr} : {mem_addr, ~mem_addr};
            end else if (mem_req && !mem_ack) begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end
endmodule

// ===== test/port_config_word_loader_bench.sv
// Self-checking bench for the port configuration word loader
`timescale 1ns/1ps
module port_config_word_loader_bench;
    import cfg_loader_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic clk_en = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic content_sel = 1'b0;
    logic [3:0] wait_cycles = 4'h0;
    logic [7:0] err_addr = 8'h00;
    wire logic hready, hresp, mem_req, mem_ack, mem_err, cfg_ready;
    wire logic [31:0] hrdata;
    wire logic [7:0] mem_addr;
    wire logic [15:0] mem_rdata;
    pm_fields_t port4_pm, port5_pm;
    dn_fields_t port0_dn, port1_dn;
    int fail_count = 0;
    int checks = 0;
    initial forever #2.5 hclk = ~hclk;
    port_config_word_loader port_config_word_loader_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata), .port4_pm(port4_pm),
        .port5_pm(port5_pm), .port0_dn(port0_dn), .port1_dn(port1_dn), .cfg_ready(cfg_ready));
    cfg_word_memory cfg_word_memory_inst (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_addr(mem_addr),
        .content_sel(content_sel), .wait_cycles(wait_cycles), .err_addr(err_addr), .mem_ack(mem_ack),
        .mem_err(mem_err), .mem_rdata(mem_rdata));
    // ----------------------------------------------------------------
    // Shared tasks and expectations
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("Counts: %0d checks, %0d mismatches", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // Bounded wait for hready or for cfg_ready, sampled at rising edges
    task automatic wait_edge(input logic on_bus);
        int n;
        n = 0;
        @(posedge hclk);
        while ((on_bus ? hready : cfg_ready) !== 1'b1) begin
            n++;
            if (n > 400) begin
                fail_count++;
                $display("Error at %0t: wait ran out", $time);
                give_verdict();
            end
            @(posedge hclk);
        end
    endtask
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_edge(1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_edge(1'b1);
        rd = hrdata;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        bus(a, 1'b0, 32'h0, d);
        check(d, exp, "register read");
    endtask
    function automatic logic [15:0] word_of(input logic [7:0] a, input logic s);
        return s ? {~a, a} : {a, ~a};
    endfunction
    function automatic pm_fields_t pm_of(input logic [15:0] w, input logic [15:0] d);
        return '{nsr: w[0], aux: w[3:1], d1: w[4], d2: w[5], pme: w[7:6], data: d[15:8]};
    endfunction
    function automatic dn_fields_t dn_of(input logic [15:0] w, input logic impl);
        return '{slot_impl: impl & w[0], slot_clk: w[1], dsi: w[2], lpvc: w[3], port_num: w[6:4], tc_map: w[15:9]};
    endfunction
    task automatic rd_dn(input logic [7:0] b, input dn_fields_t e);
        rd_chk({24'h0, b}, {10'h0, e.dsi, 21'h0});
        rd_chk({24'h0, b + 8'h04}, {5'h0, e.port_num, 24'h0});
        rd_chk({24'h0, b + 8'h08}, {3'h0, e.slot_clk, 28'h0});
        rd_chk({24'h0, b + 8'h0c}, {27'h0, e.lpvc, 4'h0});
        rd_chk({24'h0, b + 8'h10}, {24'h0, e.tc_map, 1'h0});
    endtask
    // Port outputs and register images against the words the memory held
    task automatic check_fields(input logic s, input logic s5d);
        pm_fields_t e4, e5;
        dn_fields_t e0, e1;
        e4 = pm_of(word_of(WADDR_P4_PM, s), word_of(WADDR_P4_DATA, s));
        e5 = pm_of(word_of(WADDR_P5_PM, s), word_of(WADDR_P5_DATA, s5d));
        e0 = dn_of(word_of(WADDR_P0_DN, s), 1'b0);
        e1 = dn_of(word_of(WADDR_P1_DN, s), 1'b1);
        check(32'(port4_pm), 32'(e4), "port4 fields");
        check(32'(port5_pm), 32'(e5), "port5 fields");
        check(32'(port0_dn), 32'(e0), "port0 fields");
        check(32'(port1_dn), 32'(e1), "port1 fields");
        rd_chk({24'h0, OFS_P4_40}, {2'h0, e4.pme, 1'h0, e4.d2, e4.d1, e4.aux, 22'h0});
        rd_chk({24'h0, OFS_P4_44}, {e4.data, 20'h0, e4.nsr, 3'h0});
        rd_chk({24'h0, OFS_P5_40}, {2'h0, e5.pme, 1'h0, e5.d2, e5.d1, e5.aux, 22'h0});
        rd_chk({24'h0, OFS_P5_44}, {e5.data, 20'h0, e5.nsr, 3'h0});
        rd_dn(OFS_P0_40, e0);
        rd_dn(OFS_P1_40, e1);
        rd_chk({24'h0, OFS_P1_C0}, {7'h0, e1.slot_impl, 24'h0});
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset();
        repeat (20) @(posedge hclk);
        check(32'(port4_pm), 32'(PM_RST), "port4 default");
        check(32'(port1_dn), 32'(P1_RST), "port1 default");
        check({31'h0, cfg_ready}, 32'h0, "ready in reset");
        hresetn <= 1'b1;
        $display("Test reset finished");
    endtask
    task automatic test_first_load();
        wait_edge(1'b0);
        check_fields(1'b0, 1'b0);
        rd_chk({24'h0, OFS_STATUS}, 32'h0000_3f01);
        $display("Test first load finished");
    endtask
    task automatic test_bus_edges();
        logic [31:0] d;
        logic [15:0] w58, w59;
        w58 = word_of(WADDR_P4_PM, 1'b0);
        w59 = word_of(WADDR_P4_DATA, 1'b0);
        bus({24'h0, OFS_P4_44}, 1'b1, 32'hffff_ffff, d);
        rd_chk({24'h0, OFS_P4_44}, {w59[15:8], 20'h0, w58[0], 3'h0});
        rd_chk(32'h0000_004c, 32'h0);
        rd_chk({24'h1, OFS_P4_44}, 32'h0);
        rd_chk({24'h0, OFS_CTRL}, 32'h0);
        $display("Test bus edges finished");
    endtask
    task automatic test_reload();
        logic [31:0] d;
        logic [7:0] held;
        content_sel <= 1'b1;
        wait_cycles <= 4'h4;
        err_addr <= WADDR_P5_DATA;
        bus({24'h0, OFS_CTRL}, 1'b1, 32'h1, d);
        repeat (4) @(posedge hclk);
        held = mem_addr;
        clk_en <= 1'b0;
        repeat (8) @(posedge hclk);
        check({24'h0, mem_addr}, {24'h0, held}, "frozen address");
        check(32'(port4_pm), 32'(pm_of(word_of(WADDR_P4_PM, 1'b0), word_of(WADDR_P4_DATA, 1'b0))), "frozen fields");
        check({31'h0, cfg_ready}, 32'h0, "ready during reload");
        clk_en <= 1'b1;
        wait_edge(1'b0);
        check_fields(1'b1, 1'b0);
        rd_chk({24'h0, OFS_STATUS}, 32'h0000_3701);
        $display("Test reload finished");
    endtask
    initial begin
        test_reset();
        test_first_load();
        test_bus_edges();
        test_reload();
        give_verdict();
    end
endmodule
